// *** lpw_regs.svh ***
`ifndef LPW_REGS_SVH
`define LPW_REGS_SVH

// vector pair start addresses
`define LPW_VEC_RESET     16'hFFFE
`define LPW_VEC_EXT_IRQ   16'hFFFA
`define LPW_VEC_BREAK     16'hFFFC
`define LPW_VEC_PLL       16'hFFF8
`define LPW_VEC_T1_OVF    16'hFFF2
`define LPW_VEC_T1_CH1    16'hFFF4
`define LPW_VEC_T1_CH0    16'hFFF6
`define LPW_VEC_T2_OVF    16'hFFEC
`define LPW_VEC_T2_CH1    16'hFFEE
`define LPW_VEC_T2_CH0    16'hFFF0
`define LPW_VEC_SPI_TX    16'hFFE8
`define LPW_VEC_SPI_RX    16'hFFEA
`define LPW_VEC_SCI_TX    16'hFFE2
`define LPW_VEC_SCI_RX    16'hFFE4
`define LPW_VEC_SCI_ERR   16'hFFE6
`define LPW_VEC_KEYPAD    16'hFFE0
`define LPW_VEC_ADC       16'hFFDE
`define LPW_VEC_TIMEBASE  16'hFFDC

// stop recovery, in ref_clk cycles
`define LPW_REC_LONG      12'hFFF
`define LPW_REC_SHORT     12'h01F
`define LPW_REC_ZERO      12'h000
`define LPW_REC_STEP      12'h001

// keypad pins idle high, so the edge history starts there and no false edge follows reset
`define LPW_KP_IDLE       8'hFF

`endif

// *** lpw_pkg.sv ***
package lpw_pkg;
    typedef enum logic [1:0] {
        LPW_RUN,
        LPW_WAIT,
        LPW_STOP,
        LPW_RECOVER
    } lpw_state_e;
    typedef logic [15:0] lpw_vec_t;
endpackage

// *** lpw_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpw_sync (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // level in and out
    input wire logic d,
    output logic q
);
    logic stage1;
    logic next_stage1;
    logic next_q;

    always_comb begin
        next_stage1 = d;
        next_q = stage1;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage1 <= 1'b1;
            q <= 1'b1;
        end else begin
            stage1 <= next_stage1;
            q <= next_q;
        end
    end
endmodule
`default_nettype wire

// *** lpw_vec_sel.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpw_vec_sel
    import lpw_pkg::*;
(
    // wake requests, already qualified for the current mode
    input wire logic is_reset,
    input wire logic ext_irq,
    input wire logic brk,
    input wire logic pll,
    input wire logic [2:0] t1,
    input wire logic [2:0] t2,
    input wire logic [1:0] spi,
    input wire logic [2:0] sci,
    input wire logic keypad,
    input wire logic adc,
    input wire logic timebase,
    // selected pair
    output lpw_vec_t vec
);
`include "lpw_regs.svh"

    // fixed priority: resets first, then highest vector address
    always_comb begin
        if (is_reset) vec = `LPW_VEC_RESET;
        else if (brk) vec = `LPW_VEC_BREAK;
        else if (ext_irq) vec = `LPW_VEC_EXT_IRQ;
        else if (pll) vec = `LPW_VEC_PLL;
        else if (t1[2]) vec = `LPW_VEC_T1_CH0;
        else if (t1[1]) vec = `LPW_VEC_T1_CH1;
        else if (t1[0]) vec = `LPW_VEC_T1_OVF;
        else if (t2[2]) vec = `LPW_VEC_T2_CH0;
        else if (t2[1]) vec = `LPW_VEC_T2_CH1;
        else if (t2[0]) vec = `LPW_VEC_T2_OVF;
        else if (spi[1]) vec = `LPW_VEC_SPI_RX;
        else if (spi[0]) vec = `LPW_VEC_SPI_TX;
        else if (sci[2]) vec = `LPW_VEC_SCI_ERR;
        else if (sci[1]) vec = `LPW_VEC_SCI_RX;
        else if (sci[0]) vec = `LPW_VEC_SCI_TX;
        else if (keypad) vec = `LPW_VEC_KEYPAD;
        else if (adc) vec = `LPW_VEC_ADC;
        else if (timebase) vec = `LPW_VEC_TIMEBASE;
        else vec = `LPW_VEC_RESET;
    end
endmodule
`default_nettype wire

// *** lpw_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpw_core
    import lpw_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // cpu requests
    input wire logic wait_req,
    input wire logic stop_req,
    input wire logic vector_ack,
    // configuration
    input wire logic osc_run_in_stop,
    input wire logic short_recovery_select,
    // wake sources from pins
    input wire logic reset_pin_n,
    input wire logic ext_irq_pin_n,
    input wire logic [7:0] keypad_pins_n,
    // wake sources from on-chip logic
    input wire logic watchdog_timeout,
    input wire logic low_voltage_reset,
    input wire logic break_irq,
    input wire logic pll_irq,
    input wire logic keypad_irq,
    input wire logic [2:0] timer_one_irq,
    input wire logic [2:0] timer_two_irq,
    input wire logic [1:0] sync_serial_irq,
    input wire logic [2:0] async_serial_irq,
    input wire logic adc_irq,
    input wire logic timebase_irq,
    // clock gating
    output logic cpu_clk_en,
    output logic bus_clk_en,
    output logic osc_en,
    output logic pll_en,
    output logic clkgen_out_en,
    // peripheral controls
    output logic async_serial_run,
    output logic sync_serial_run,
    output logic sync_serial_abort,
    output logic timer_run,
    output logic timebase_run,
    output logic timebase_reg_access,
    // system reset and vector
    output logic sys_reset,
    output logic vector_valid,
    output lpw_vec_t vector_addr,
    output lpw_state_e mode
);
`include "lpw_regs.svh"

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic reset_pin_s;
    logic ext_irq_s;
    logic [7:0] keypad_s;

    lpw_sync u_sync_rst (
        .ref_clk(ref_clk),
        .rst(rst),
        .d(reset_pin_n),
        .q(reset_pin_s)
    );
    lpw_sync u_sync_irq (
        .ref_clk(ref_clk),
        .rst(rst),
        .d(ext_irq_pin_n),
        .q(ext_irq_s)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_kp
            lpw_sync u_sync_kp (
                .ref_clk(ref_clk),
                .rst(rst),
                .d(keypad_pins_n[gi]),
                .q(keypad_s[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // edge detection
    // ----------------------------------------------------------------
    logic ext_irq_d;
    logic [7:0] keypad_d;
    logic next_ext_irq_d;
    logic [7:0] next_keypad_d;
    logic ext_fall;
    logic keypad_fall;

    always_comb begin
        next_ext_irq_d = ext_irq_s;
        next_keypad_d = keypad_s;
        ext_fall = ext_irq_d & ~ext_irq_s;
        keypad_fall = |(keypad_d & ~keypad_s);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ext_irq_d <= 1'b1;
            keypad_d <= `LPW_KP_IDLE;
        end else begin
            ext_irq_d <= next_ext_irq_d;
            keypad_d <= next_keypad_d;
        end
    end

    // ----------------------------------------------------------------
    // wake qualification
    // ----------------------------------------------------------------
    logic in_stop;
    logic reset_wake;
    logic irq_wake;
    logic wake_wait;
    logic wake_stop_int;
    logic tb_live_stop;
    lpw_vec_t sel_vec;

    always_comb begin
        in_stop = (mode == LPW_STOP);
        tb_live_stop = osc_run_in_stop;
        // watchdog clock is off in stop, so it only counts outside it
        reset_wake = ~reset_pin_s | low_voltage_reset
            | (watchdog_timeout & ~in_stop);
        wake_wait = ext_fall | break_irq | pll_irq | keypad_irq
            | (|timer_one_irq) | (|timer_two_irq)
            | (|sync_serial_irq) | (|async_serial_irq)
            | adc_irq | timebase_irq;
        wake_stop_int = ext_fall | keypad_fall | break_irq
            | (timebase_irq & tb_live_stop);
        irq_wake = in_stop ? wake_stop_int : wake_wait;
    end

    lpw_vec_sel u_vec_sel (
        .is_reset(reset_wake),
        .ext_irq(ext_fall),
        .brk(break_irq),
        .pll(pll_irq & ~in_stop),
        .t1(in_stop ? 3'b000 : timer_one_irq),
        .t2(in_stop ? 3'b000 : timer_two_irq),
        .spi(in_stop ? 2'b00 : sync_serial_irq),
        .sci(in_stop ? 3'b000 : async_serial_irq),
        .keypad(in_stop ? keypad_fall : keypad_irq),
        .adc(adc_irq & ~in_stop),
        .timebase(timebase_irq & (~in_stop | tb_live_stop)),
        .vec(sel_vec)
    );

    // ----------------------------------------------------------------
    // mode machine and stop recovery counter
    // ----------------------------------------------------------------
    lpw_state_e next_mode;
    logic [11:0] rec_cnt;
    logic [11:0] next_rec_cnt;
    lpw_vec_t next_vector_addr;
    logic next_vector_valid;
    logic next_sys_reset;
    logic next_spi_abort;
    logic spi_abort;

    always_comb begin
        next_mode = mode;
        next_rec_cnt = rec_cnt;
        next_vector_addr = vector_addr;
        next_vector_valid = vector_valid & ~vector_ack;
        next_sys_reset = 1'b0;
        next_spi_abort = 1'b0;
        unique case (mode)
            LPW_RUN: begin
                if (reset_wake) begin
                    next_sys_reset = 1'b1;
                    next_vector_addr = `LPW_VEC_RESET;
                    next_vector_valid = 1'b1;
                end else if (stop_req) begin
                    next_mode = LPW_STOP;
                end else if (wait_req) begin
                    next_mode = LPW_WAIT;
                end
            end
            LPW_WAIT: begin
                if (reset_wake | irq_wake) begin
                    next_sys_reset = reset_wake;
                    next_vector_addr = sel_vec;
                    next_vector_valid = 1'b1;
                    next_mode = LPW_RUN;
                end
            end
            LPW_STOP: begin
                if (reset_wake | irq_wake) begin
                    next_sys_reset = reset_wake;
                    next_spi_abort = reset_wake;
                    next_vector_addr = sel_vec;
                    next_rec_cnt = short_recovery_select ? `LPW_REC_SHORT
                        : `LPW_REC_LONG;
                    next_mode = LPW_RECOVER;
                end
            end
            LPW_RECOVER: begin
                if (rec_cnt == `LPW_REC_ZERO) begin
                    next_vector_valid = 1'b1;
                    next_mode = LPW_RUN;
                end else begin
                    next_rec_cnt = rec_cnt - `LPW_REC_STEP;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode <= LPW_RUN;
            rec_cnt <= `LPW_REC_ZERO;
            vector_addr <= `LPW_VEC_RESET;
            vector_valid <= 1'b1;
            sys_reset <= 1'b1;
            spi_abort <= 1'b0;
        end else begin
            mode <= next_mode;
            rec_cnt <= next_rec_cnt;
            vector_addr <= next_vector_addr;
            vector_valid <= next_vector_valid;
            sys_reset <= next_sys_reset;
            spi_abort <= next_spi_abort;
        end
    end

    // ----------------------------------------------------------------
    // clock and peripheral gating
    // ----------------------------------------------------------------
    // recovery keeps the oscillator and clkgen output up but the cpu, bus and pll clocks held off;
    // flopped from next_mode so a two-bit state change cannot glitch an enable
    logic next_awake;
    logic next_cpu_clk_en;
    logic next_bus_clk_en;
    logic next_osc_en;
    logic next_pll_en;
    logic next_clkgen_out_en;
    logic next_async_serial_run;
    logic next_sync_serial_run;
    logic next_timer_run;
    logic next_timebase_run;
    logic next_timebase_reg_access;

    always_comb begin
        next_awake = (next_mode == LPW_RUN) | (next_mode == LPW_WAIT);
        next_cpu_clk_en = (next_mode == LPW_RUN);
        next_bus_clk_en = next_awake;
        next_osc_en = (next_mode != LPW_STOP) | osc_run_in_stop;
        next_pll_en = next_awake;
        next_clkgen_out_en = (next_mode != LPW_STOP) | osc_run_in_stop;
        next_async_serial_run = next_awake;
        next_sync_serial_run = next_awake;
        next_timer_run = next_awake;
        next_timebase_run = (next_mode != LPW_STOP) | tb_live_stop;
        next_timebase_reg_access = (next_mode == LPW_RUN);
        sync_serial_abort = spi_abort;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cpu_clk_en <= 1'b1;
            bus_clk_en <= 1'b1;
            osc_en <= 1'b1;
            pll_en <= 1'b1;
            clkgen_out_en <= 1'b1;
            async_serial_run <= 1'b1;
            sync_serial_run <= 1'b1;
            timer_run <= 1'b1;
            timebase_run <= 1'b1;
            timebase_reg_access <= 1'b1;
        end else begin
            cpu_clk_en <= next_cpu_clk_en;
            bus_clk_en <= next_bus_clk_en;
            osc_en <= next_osc_en;
            pll_en <= next_pll_en;
            clkgen_out_en <= next_clkgen_out_en;
            async_serial_run <= next_async_serial_run;
            sync_serial_run <= next_sync_serial_run;
            timer_run <= next_timer_run;
            timebase_run <= next_timebase_run;
            timebase_reg_access <= next_timebase_reg_access;
        end
    end
endmodule
`default_nettype wire

// *** lpw_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpw_cpu_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // vector handshake
    input wire logic vector_valid,
    input wire logic [1:0] ack_delay,
    output logic vector_ack
);
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic next_ack;
    // one ack per vector; delay varies to cover prompt and slow fetch
    always_comb begin
        next_ack = vector_valid && !vector_ack && cnt == ack_delay;
        next_cnt = (vector_valid && !vector_ack && !next_ack) ? cnt + 2'h1 : 2'h0;
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt <= 2'h0;
            vector_ack <= 1'b0;
        end else begin
            cnt <= next_cnt;
            vector_ack <= next_ack;
        end
    end
endmodule
`default_nettype wire

// *** lpw_core_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lpw_regs.svh"
module lpw_core_properties
    import lpw_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // watched signals
    input wire logic vector_ack,
    input wire logic osc_run_in_stop,
    input wire logic short_recovery_select,
    input wire logic break_irq,
    input wire logic watchdog_timeout,
    input wire logic low_voltage_reset,
    input wire logic cpu_clk_en,
    input wire logic bus_clk_en,
    input wire logic osc_en,
    input wire logic pll_en,
    input wire logic clkgen_out_en,
    input wire logic async_serial_run,
    input wire logic sync_serial_run,
    input wire logic sync_serial_abort,
    input wire logic timer_run,
    input wire logic timebase_run,
    input wire logic timebase_reg_access,
    input wire logic sys_reset,
    input wire logic vector_valid,
    input wire lpw_vec_t vector_addr,
    input wire lpw_state_e mode
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [12:0] rec_cnt;
    logic [12:0] next_rec_cnt;
    always_comb begin
        next_rec_cnt = (mode == LPW_RECOVER) ? rec_cnt + 13'h0001 : 13'h0000;
    end
    always_ff @(posedge ref_clk) begin
        rec_cnt <= rst ? 13'h0000 : next_rec_cnt;
    end
    property p_stop_clk;
        mode == LPW_STOP |-> !cpu_clk_en && !pll_en && osc_en == osc_run_in_stop
            && (osc_run_in_stop || !clkgen_out_en);
    endproperty
    a_stop_clk: assert property (p_stop_clk) else $error("clock gating wrong in stop");
    property p_stop_units;
        mode == LPW_STOP |-> !timer_run && !async_serial_run && !sync_serial_run;
    endproperty
    a_stop_units: assert property (p_stop_units) else $error("unit runs in stop");
    property p_tb_lock;
        mode inside {LPW_WAIT, LPW_STOP} |-> !timebase_reg_access
            && (mode == LPW_STOP || timebase_run);
    endproperty
    a_tb_lock: assert property (p_tb_lock) else $error("timebase wrong in wait");
    property p_tb_stop;
        mode == LPW_STOP |-> timebase_run == osc_run_in_stop;
    endproperty
    a_tb_stop: assert property (p_tb_stop) else $error("timebase wrong in stop");
    // recovery length counted from entry into recover to the return to run
    property p_rec_len;
        mode == LPW_RUN && $past(mode) == LPW_RECOVER |-> vector_valid
            && rec_cnt == (short_recovery_select ? 13'h0020 : 13'h1000);
    endproperty
    a_rec_len: assert property (p_rec_len) else $error("recovery length wrong");
    property p_brk_wait;
        mode == LPW_WAIT && break_irq && !watchdog_timeout && !low_voltage_reset |=>
            mode == LPW_RUN && vector_valid && vector_addr == `LPW_VEC_BREAK;
    endproperty
    a_brk_wait: assert property (p_brk_wait) else $error("break wake from wait wrong");
    property p_brk_stop;
        mode == LPW_STOP && break_irq && !low_voltage_reset |=>
            mode == LPW_RECOVER && vector_addr == `LPW_VEC_BREAK;
    endproperty
    a_brk_stop: assert property (p_brk_stop) else $error("break wake from stop wrong");
    property p_lvr;
        mode == LPW_WAIT && low_voltage_reset |=> sys_reset && vector_addr == `LPW_VEC_RESET;
    endproperty
    a_lvr: assert property (p_lvr) else $error("reset wake wrong");
    property p_ack;
        vector_valid && vector_ack && mode == LPW_RUN && !sys_reset |=> !vector_valid;
    endproperty
    a_ack: assert property (p_ack) else $error("vector not cleared by ack");
    property p_rec_clk;
        mode == LPW_RECOVER |-> !cpu_clk_en && !bus_clk_en && !pll_en && osc_en;
    endproperty
    a_rec_clk: assert property (p_rec_clk) else $error("clock on during recovery");
    property p_wait_clk;
        mode == LPW_WAIT |-> !cpu_clk_en && bus_clk_en && pll_en;
    endproperty
    a_wait_clk: assert property (p_wait_clk) else $error("clock gating wrong in wait");
    property p_abort;
        sync_serial_abort |-> sys_reset && mode == LPW_RECOVER && $past(mode) == LPW_STOP;
    endproperty
    a_abort: assert property (p_abort) else $error("bad serial abort");
    property p_abort_set;
        mode == LPW_STOP && low_voltage_reset |=> sync_serial_abort;
    endproperty
    a_abort_set: assert property (p_abort_set) else $error("no serial abort");
    c_abort: cover property (sync_serial_abort);
    c_wait: cover property (mode == LPW_WAIT ##1 mode == LPW_RUN);
    c_short: cover property (mode == LPW_RECOVER && short_recovery_select);
    c_long: cover property (mode == LPW_RECOVER && !short_recovery_select);
endmodule
bind lpw_core lpw_core_properties u_props (.ref_clk, .rst, .vector_ack, .osc_run_in_stop,
    .short_recovery_select, .break_irq, .watchdog_timeout, .low_voltage_reset, .cpu_clk_en,
    .bus_clk_en, .osc_en, .pll_en, .clkgen_out_en, .async_serial_run, .sync_serial_run,
    .sync_serial_abort, .timer_run, .timebase_run, .timebase_reg_access, .sys_reset,
    .vector_valid, .vector_addr, .mode);
`default_nettype wire

// *** low_power_wake_and_vector_select_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lpw_regs.svh"
module low_power_wake_and_vector_select_tb
    import lpw_pkg::*;
();
    logic ref_clk = 1'b0, rst = 1'b1, wait_req = 1'b0, stop_req = 1'b0;
    logic osc_run_in_stop = 1'b0, short_recovery_select = 1'b1;
    logic reset_pin_n = 1'b1, ext_irq_pin_n = 1'b1, watchdog_timeout = 1'b0;
    logic low_voltage_reset = 1'b0, break_irq = 1'b0, pll_irq = 1'b0, keypad_irq = 1'b0;
    logic adc_irq = 1'b0, timebase_irq = 1'b0, vector_ack, vector_valid;
    logic [7:0] keypad_pins_n = 8'hff;
    logic [2:0] timer_one_irq = 3'h0, timer_two_irq = 3'h0, async_serial_irq = 3'h0;
    logic [1:0] sync_serial_irq = 2'h0, ack_delay = 2'h0;
    lpw_vec_t vector_addr;
    lpw_state_e mode;
    int err_total = 0, cmp_count = 0, kp_bit = 0;
    lpw_vec_t exp_q[$];
    lpw_vec_t ev;
    lpw_vec_t vtab[21] = '{`LPW_VEC_BREAK, `LPW_VEC_PLL, `LPW_VEC_T1_OVF, `LPW_VEC_T1_CH1,
        `LPW_VEC_T1_CH0, `LPW_VEC_T2_OVF, `LPW_VEC_T2_CH1, `LPW_VEC_T2_CH0, `LPW_VEC_SPI_TX,
        `LPW_VEC_SPI_RX, `LPW_VEC_SCI_TX, `LPW_VEC_SCI_RX, `LPW_VEC_SCI_ERR, `LPW_VEC_KEYPAD,
        `LPW_VEC_ADC, `LPW_VEC_TIMEBASE, `LPW_VEC_RESET, `LPW_VEC_RESET, `LPW_VEC_EXT_IRQ,
        `LPW_VEC_KEYPAD, `LPW_VEC_RESET};
    int s_k[8] = '{0, 18, 19, 17, 20, 15, 0, 0};
    int s_bad[8] = '{1, 16, 13, 2, 14, -1, 15, -1};
    lpw_core dut (.ref_clk, .rst, .wait_req, .stop_req, .vector_ack, .osc_run_in_stop,
        .short_recovery_select, .reset_pin_n, .ext_irq_pin_n, .keypad_pins_n,
        .watchdog_timeout, .low_voltage_reset, .break_irq, .pll_irq, .keypad_irq,
        .timer_one_irq, .timer_two_irq, .sync_serial_irq, .async_serial_irq, .adc_irq,
        .timebase_irq, .cpu_clk_en(), .bus_clk_en(), .osc_en(), .pll_en(), .clkgen_out_en(),
        .async_serial_run(), .sync_serial_run(), .sync_serial_abort(), .timer_run(),
        .timebase_run(), .timebase_reg_access(), .sys_reset(), .vector_valid, .vector_addr,
        .mode);
    lpw_cpu_model cpu (.ref_clk, .rst, .vector_valid, .ack_delay, .vector_ack);
    always #12.5 ref_clk = ~ref_clk;
    // ----
    // checks and helpers
    // ----
    task automatic fail(input string msg);
        err_total++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask
    task automatic cmp_vec(input lpw_vec_t exp);
        cmp_count++;
        if (vector_addr !== exp) fail($sformatf("vector %h, expected %h", vector_addr, exp));
    endtask
    task automatic cmp_mode(input lpw_state_e exp);
        cmp_count++;
        if (mode !== exp) fail($sformatf("mode %0d, expected %0d", mode, exp));
    endtask
    task automatic wait_vv(input logic v);
        for (int i = 0; i < 6000 && vector_valid !== v; i++) @(posedge ref_clk);
        if (vector_valid !== v) fail("vector handshake stuck");
    endtask
    // index: 0..15 interrupts, 16 watchdog, 17 low voltage with break, 18..20 pins
    task automatic set_src(input int k, input logic on);
        case (k)
            0: break_irq <= on;
            1: pll_irq <= on;
            2, 3, 4: timer_one_irq[k - 2] <= on;
            5, 6, 7: timer_two_irq[k - 5] <= on;
            8, 9: sync_serial_irq[k - 8] <= on;
            10, 11, 12: async_serial_irq[k - 10] <= on;
            13: keypad_irq <= on;
            14: adc_irq <= on;
            15: timebase_irq <= on;
            16: watchdog_timeout <= on;
            17: {low_voltage_reset, break_irq} <= {on, on};
            18: ext_irq_pin_n <= !on;
            19: keypad_pins_n[kp_bit] <= !on;
            default: reset_pin_n <= !on;
        endcase
    endtask
    task automatic wake(input int k, input logic stp, input int bad, input logic osc,
        input logic shrt);
        wait_vv(1'b0);
        kp_bit = $urandom % 8;
        @(posedge ref_clk);
        {osc_run_in_stop, short_recovery_select, stop_req, wait_req} <= {osc, shrt, stp, !stp};
        ack_delay <= 2'($urandom);
        @(posedge ref_clk);
        {stop_req, wait_req} <= 2'h0;
        #1 cmp_mode(stp ? LPW_STOP : LPW_WAIT);
        if (bad >= 0) begin
            @(posedge ref_clk) set_src(bad, 1'b1);
            repeat (8) @(posedge ref_clk);
            #1 cmp_mode(LPW_STOP);
            @(posedge ref_clk) set_src(bad, 1'b0);
        end
        @(posedge ref_clk) set_src(k, 1'b1);
        exp_q.push_back(vtab[k]);
        // pins pulse once so a reset is not seen again in run
        if (k >= 18) @(posedge ref_clk) set_src(k, 1'b0);
        for (int i = 0; i < 8 && mode inside {LPW_WAIT, LPW_STOP}; i++) @(posedge ref_clk);
        set_src(k, 1'b0);
        #1 cmp_mode(stp ? LPW_RECOVER : LPW_RUN);
        wait_vv(1'b1);
        $display("test %0d stop %0d done", k, stp);
    endtask
    // ----
    // result monitor and run control
    // ----
    always @(posedge ref_clk) begin
        if (vector_valid === 1'b1 && vector_ack === 1'b1) begin
            if (exp_q.size() == 0) fail("unexpected vector");
            else begin
                ev = exp_q.pop_front();
                cmp_vec(ev);
            end
        end
    end
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #1_000_000;
        fail("watchdog expired");
        complete_run();
    end
    initial begin
        void'($urandom(32'he5e9_8a5f));
        exp_q.push_back(`LPW_VEC_RESET);
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        for (int k = 0; k < 21; k++) begin
            if (k != 19) wake(k, 1'b0, -1, 1'b0, 1'b1);
        end
        for (int i = 0; i < 8; i++) begin
            wake(s_k[i], 1'b1, s_bad[i], i == 5, i != 7);
        end
        wait_vv(1'b0);
        if (exp_q.size() != 0) fail("vector missing");
        complete_run();
    end
endmodule
`default_nettype wire
